//--- hdl/pcrc_cfg.svh
// constants of the programmable crc generator: offsets, field positions, counts
// assumes a 32-bit avalon-mm slave with byte addresses and 16-bit wide registers
`ifndef PCRC_CFG_SVH
`define PCRC_CFG_SVH

// ==========================================================================
// register byte offsets
`define PCRC_OFF_CONTROL   5'h00
`define PCRC_OFF_CONFIG    5'h04
`define PCRC_OFF_TERMS_LO  5'h08
`define PCRC_OFF_TERMS_HI  5'h0C
`define PCRC_OFF_DATA_LO   5'h10
`define PCRC_OFF_DATA_HI   5'h14
`define PCRC_OFF_RESULT_LO 5'h18
`define PCRC_OFF_RESULT_HI 5'h1C

// ==========================================================================
// field positions
`define PCRC_CTL_EN        15
`define PCRC_CTL_CNT_LSB   8
`define PCRC_CTL_FULL      7
`define PCRC_CTL_EMPTY     6
`define PCRC_CTL_ISEL      5
`define PCRC_CTL_GO        4
`define PCRC_CTL_DIR       3
`define PCRC_CFG_DW_LSB    8
`define PCRC_CFG_PL_LSB    0

// ==========================================================================
// counts and values
`define PCRC_DEPTH_WIDE    5'h04
`define PCRC_DEPTH_MID     5'h08
`define PCRC_DEPTH_NARROW  5'h10
`define PCRC_DW_WIDE_MIN   5'h10
`define PCRC_DW_MID_MIN    5'h08
`define PCRC_MAX_IDX       5'h1F
`define PCRC_ALL_ONES      32'hFFFFFFFF
`define PCRC_ZERO32        32'h00000000
`define PCRC_FIFO_AW       4
`define PCRC_FIFO_DEPTH    16
`define PCRC_WORD_W        32

`endif

//--- hdl/pcrc_pkg.sv
// types and helpers shared by the crc generator modules
// assumes pcrc_cfg.svh is on the include path
`include "pcrc_cfg.svh"

package pcrc_pkg;

	// ======================================================================
	// engine sequencing states
	typedef enum logic [1:0] {
		PCRC_ST_IDLE  = 2'b00,
		PCRC_ST_LOAD  = 2'b01,
		PCRC_ST_SHIFT = 2'b10,
		PCRC_ST_FLUSH = 2'b11
	} pcrc_state_e;

	// software configuration carried as one group
	typedef struct packed {
		logic       enable;
		logic       isel;
		logic       dir;
		logic [4:0] dwidth;
		logic [4:0] plen;
	} pcrc_cfg_s;

	// merge a 16-bit write into a register by byte enables
	function automatic logic [15:0] pcrc_merge16(input logic [15:0] old_v,
		input logic [15:0] new_v, input logic [1:0] be);
		logic [15:0] res;
		res = old_v;
		if (be[0]) begin
			res[7:0] = new_v[7:0];
		end
		if (be[1]) begin
			res[15:8] = new_v[15:8];
		end
		return res;
	endfunction : pcrc_merge16

endpackage : pcrc_pkg

//--- hdl/pcrc_mem.sv
// word store of the input fifo, registered read data
// assumes the caller keeps the pointers and never reads and writes out of range
`include "pcrc_cfg.svh"

module pcrc_mem (
	// clock
	input  wire logic                      clk,
	// write side
	input  wire logic                      wr_en,
	input  wire logic [`PCRC_FIFO_AW-1:0]  wr_addr,
	input  wire logic [`PCRC_WORD_W-1:0]   wr_data,
	// read side
	input  wire logic                      rd_en,
	input  wire logic [`PCRC_FIFO_AW-1:0]  rd_addr,
	output logic      [`PCRC_WORD_W-1:0]   rd_data
);
	import pcrc_pkg::*;

	logic [`PCRC_WORD_W-1:0] store_reg [`PCRC_FIFO_DEPTH];

	// ======================================================================
	// storage write
	always_ff @(posedge clk) begin
		if (wr_en) begin
			store_reg[wr_addr] <= wr_data;
		end
	end

	// read data held in a register
	always_ff @(posedge clk) begin
		if (rd_en) begin
			rd_data <= store_reg[rd_addr];
		end
	end

endmodule : pcrc_mem

//--- hdl/pcrc_engine.sv
// crc shift engine holding the result, one or two data bits per cycle
// assumes the poly input has bit zero set and plen is the order minus one
`include "pcrc_cfg.svh"

module pcrc_engine (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic        clear,
	// software access to the result pair
	input  wire logic        wr_lo,
	input  wire logic        wr_hi,
	input  wire logic [15:0] wr_data,
	input  wire logic [1:0]  wr_be,
	// shifting
	input  wire logic        shift_en,
	input  wire logic        two_bits,
	input  wire logic        bit_a,
	input  wire logic        bit_b,
	input  wire logic [31:0] poly,
	input  wire logic [4:0]  plen,
	// result
	output logic      [31:0] result
);
	import pcrc_pkg::*;

	logic [31:0] mask;
	logic [31:0] step1;
	logic [31:0] step2;

	// one bit of a normal crc: feedback from the top bit of the programmed order
	function automatic logic [31:0] crc_step(input logic [31:0] crc, input logic din,
		input logic [31:0] p, input logic [31:0] m, input logic [4:0] top);
		logic fb;
		fb = din ^ crc[top];
		return ((crc << 1) & m) ^ (fb ? (p & m) : `PCRC_ZERO32);
	endfunction : crc_step

	// ======================================================================
	// next values for one and two bits
	always_comb begin
		mask  = `PCRC_ALL_ONES >> (`PCRC_MAX_IDX - plen);
		step1 = crc_step(result, bit_a, poly, mask, plen);
		step2 = crc_step(step1, bit_b, poly, mask, plen);
	end

	// result register: software writes win over shifting
	always_ff @(posedge clk) begin
		if (srst || clear) begin
			result <= `PCRC_ZERO32;
		end else if (wr_lo) begin
			result[15:0] <= pcrc_merge16(result[15:0], wr_data, wr_be);
		end else if (wr_hi) begin
			result[31:16] <= pcrc_merge16(result[31:16], wr_data, wr_be);
		end else if (shift_en) begin
			result <= two_bits ? step2 : step1;
		end
	end

endmodule : pcrc_engine

//--- hdl/pcrc_top.sv
// programmable crc generator with input fifo behind an avalon-mm slave
// assumes one 25 MHz clock, synchronous reset, a master that holds requests
`include "pcrc_cfg.svh"

module pcrc_top (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// avalon-mm slave
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// event output
	output logic             crc_irq
);
	import pcrc_pkg::*;

	// ======================================================================
	// declarations
	pcrc_cfg_s   cfg_reg;
	logic        go_reg;
	logic [31:1] terms_reg;
	logic [31:0] stage_reg;
	logic [31:0] stage_next;
	logic [15:0] terms_lo_next;
	logic [4:0]  count_reg;
	logic [3:0]  wptr_reg;
	logic [3:0]  rptr_reg;
	logic [4:0]  depth;
	logic        full;
	logic        empty;
	logic        hit_ctl;
	logic        hit_cfg;
	logic        hit_tlo;
	logic        hit_thi;
	logic        hit_dlo;
	logic        hit_dhi;
	logic        hit_rlo;
	logic        hit_rhi;
	logic        wr_ctl;
	logic        wr_cfg;
	logic        wr_tlo;
	logic        wr_thi;
	logic        wr_dlo;
	logic        wr_dhi;
	logic        wr_rlo;
	logic        wr_rhi;
	logic [15:0] wdata16;
	logic [1:0]  be16;
	logic        msb_lane;
	logic        push_req;
	logic        push;
	logic        pop;
	logic        rd_valid_reg;
	logic [31:0] rd_mux;
	logic [31:0] result;
	logic [31:0] mem_rdata;
	logic [31:0] width_mask;
	logic [31:0] masked;
	pcrc_state_e state_reg;
	logic [31:0] buf_reg;
	logic [5:0]  bits_left_reg;
	logic [5:0]  flush_cnt_reg;
	logic [5:0]  flush_len;
	logic        last_shift;
	logic        done_pulse;
	logic        shift_en;
	logic        bit_a;
	logic        bit_b;

	// ======================================================================
	// address decode
	always_comb begin
		hit_ctl = 1'b0;
		hit_cfg = 1'b0;
		hit_tlo = 1'b0;
		hit_thi = 1'b0;
		hit_dlo = 1'b0;
		hit_dhi = 1'b0;
		hit_rlo = 1'b0;
		hit_rhi = 1'b0;
		if (avs_address == `PCRC_OFF_CONTROL) begin
			hit_ctl = 1'b1;
		end else if (avs_address == `PCRC_OFF_CONFIG) begin
			hit_cfg = 1'b1;
		end else if (avs_address == `PCRC_OFF_TERMS_LO) begin
			hit_tlo = 1'b1;
		end else if (avs_address == `PCRC_OFF_TERMS_HI) begin
			hit_thi = 1'b1;
		end else if (avs_address == `PCRC_OFF_DATA_LO) begin
			hit_dlo = 1'b1;
		end else if (avs_address == `PCRC_OFF_DATA_HI) begin
			hit_dhi = 1'b1;
		end else if (avs_address == `PCRC_OFF_RESULT_LO) begin
			hit_rlo = 1'b1;
		end else if (avs_address == `PCRC_OFF_RESULT_HI) begin
			hit_rhi = 1'b1;
		end
	end

	// writes complete with no wait, so each strobe acts in the cycle it is seen
	assign wr_ctl  = avs_write & hit_ctl;
	assign wr_cfg  = avs_write & hit_cfg;
	assign wr_tlo  = avs_write & hit_tlo;
	assign wr_thi  = avs_write & hit_thi;
	assign wr_dlo  = avs_write & hit_dlo;
	assign wr_dhi  = avs_write & hit_dhi;
	assign wr_rlo  = avs_write & hit_rlo;
	assign wr_rhi  = avs_write & hit_rhi;
	assign wdata16 = avs_writedata[15:0];
	assign be16    = avs_byteenable[1:0];

	// ======================================================================
	// reads take one wait cycle so read data come from a register
	assign avs_waitrequest = avs_read & ~rd_valid_reg;

	always_ff @(posedge clk) begin
		if (srst) begin
			rd_valid_reg <= 1'b0;
		end else begin
			rd_valid_reg <= avs_read & ~rd_valid_reg;
		end
	end

	// read mux: data pair and unmapped offsets read zero
	always_comb begin
		rd_mux = `PCRC_ZERO32;
		if (hit_ctl) begin
			rd_mux[`PCRC_CTL_EN] = cfg_reg.enable;
			rd_mux[`PCRC_CTL_CNT_LSB +: 5] = count_reg;
			rd_mux[`PCRC_CTL_FULL] = full;
			rd_mux[`PCRC_CTL_EMPTY] = empty;
			rd_mux[`PCRC_CTL_ISEL] = cfg_reg.isel;
			rd_mux[`PCRC_CTL_GO] = go_reg;
			rd_mux[`PCRC_CTL_DIR] = cfg_reg.dir;
		end else if (hit_cfg) begin
			rd_mux[`PCRC_CFG_DW_LSB +: 5] = cfg_reg.dwidth;
			rd_mux[`PCRC_CFG_PL_LSB +: 5] = cfg_reg.plen;
		end else if (hit_tlo) begin
			rd_mux[15:1] = terms_reg[15:1];
		end else if (hit_thi) begin
			rd_mux[15:0] = terms_reg[31:16];
		end else if (hit_rlo) begin
			rd_mux[15:0] = result[15:0];
		end else if (hit_rhi) begin
			rd_mux[15:0] = result[31:16];
		end else if (hit_dlo || hit_dhi) begin
			rd_mux = `PCRC_ZERO32;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			avs_readdata <= `PCRC_ZERO32;
		end else if (avs_read && !rd_valid_reg) begin
			avs_readdata <= rd_mux;
		end
	end

	// ======================================================================
	// control and configuration registers
	always_ff @(posedge clk) begin
		if (srst) begin
			cfg_reg <= '0;
		end else begin
			if (wr_ctl && be16[1]) begin
				cfg_reg.enable <= wdata16[`PCRC_CTL_EN];
			end
			if (wr_ctl && be16[0]) begin
				cfg_reg.isel <= wdata16[`PCRC_CTL_ISEL];
				cfg_reg.dir  <= wdata16[`PCRC_CTL_DIR];
			end
			if (wr_cfg && be16[1]) begin
				cfg_reg.dwidth <= wdata16[`PCRC_CFG_DW_LSB +: 5];
			end
			if (wr_cfg && be16[0]) begin
				cfg_reg.plen <= wdata16[`PCRC_CFG_PL_LSB +: 5];
			end
		end
	end

	// go bit: a software write wins over the self-clear at completion
	always_ff @(posedge clk) begin
		if (srst) begin
			go_reg <= 1'b0;
		end else if (wr_ctl && be16[0]) begin
			go_reg <= wdata16[`PCRC_CTL_GO];
		end else if (done_pulse) begin
			go_reg <= 1'b0;
		end
	end

	// polynomial term enables, bit zero not stored
	assign terms_lo_next = pcrc_merge16({terms_reg[15:1], 1'b0}, wdata16, be16);

	always_ff @(posedge clk) begin
		if (srst) begin
			terms_reg <= '0;
		end else if (wr_tlo) begin
			terms_reg[15:1] <= terms_lo_next[15:1];
		end else if (wr_thi) begin
			terms_reg[31:16] <= pcrc_merge16(terms_reg[31:16], wdata16, be16);
		end
	end

	// ======================================================================
	// input word assembly from the data pair
	always_comb begin
		stage_next = stage_reg;
		if (wr_dlo) begin
			stage_next[15:0] = pcrc_merge16(stage_reg[15:0], wdata16, be16);
		end else if (wr_dhi) begin
			stage_next[31:16] = pcrc_merge16(stage_reg[31:16], wdata16, be16);
		end
	end

	always_ff @(posedge clk) begin
		if (srst || !cfg_reg.enable) begin
			stage_reg <= `PCRC_ZERO32;
		end else begin
			stage_reg <= stage_next;
		end
	end

	// the word is pushed when the byte holding its top bit is written
	assign msb_lane = cfg_reg.dwidth[3] ? be16[1] : be16[0];
	assign push_req = (cfg_reg.dwidth[4] ? wr_dhi : wr_dlo) & msb_lane;
	assign push     = push_req & ~full & cfg_reg.enable;

	// ======================================================================
	// fifo depth, flags and pointers
	always_comb begin
		if (cfg_reg.dwidth >= `PCRC_DW_WIDE_MIN) begin
			depth = `PCRC_DEPTH_WIDE;
		end else if (cfg_reg.dwidth >= `PCRC_DW_MID_MIN) begin
			depth = `PCRC_DEPTH_MID;
		end else begin
			depth = `PCRC_DEPTH_NARROW;
		end
	end

	assign full  = (count_reg >= depth);
	assign empty = (count_reg == 5'h00);

	always_ff @(posedge clk) begin
		if (srst || !cfg_reg.enable) begin
			count_reg <= 5'h00;
			wptr_reg  <= 4'h0;
			rptr_reg  <= 4'h0;
		end else begin
			count_reg <= count_reg + {4'h0, push} - {4'h0, pop};
			if (push) begin
				wptr_reg <= wptr_reg + 4'h1;
			end
			if (pop) begin
				rptr_reg <= rptr_reg + 4'h1;
			end
		end
	end

	pcrc_mem u_mem (
		.clk     (clk),
		.wr_en   (push),
		.wr_addr (wptr_reg),
		.wr_data (stage_next),
		.rd_en   (pop),
		.rd_addr (rptr_reg),
		.rd_data (mem_rdata)
	);

	// ======================================================================
	// sequencing: fetch a word, shift it, flush at the end
	assign last_shift = (bits_left_reg <= 6'h02);
	assign pop = cfg_reg.enable & go_reg & ~empty
		& ((state_reg == PCRC_ST_IDLE)
		| ((state_reg == PCRC_ST_SHIFT) & last_shift));
	assign done_pulse = (state_reg == PCRC_ST_FLUSH) & go_reg & (flush_cnt_reg <= 6'h01);
	assign flush_len  = 6'(({1'b0, cfg_reg.plen} + 6'h01) >> 1);

	// bits above the configured width are dropped here
	assign width_mask = `PCRC_ALL_ONES >> (`PCRC_MAX_IDX - cfg_reg.dwidth);
	assign masked     = mem_rdata & width_mask;

	always_ff @(posedge clk) begin
		if (srst || !cfg_reg.enable) begin
			state_reg     <= PCRC_ST_IDLE;
			flush_cnt_reg <= 6'h00;
		end else begin
			case (state_reg)
				PCRC_ST_IDLE: begin
					if (pop) begin
						state_reg <= PCRC_ST_LOAD;
					end
				end
				PCRC_ST_LOAD: begin
					state_reg <= PCRC_ST_SHIFT;
				end
				PCRC_ST_SHIFT: begin
					if (last_shift) begin
						if (pop) begin
							state_reg <= PCRC_ST_LOAD;
						end else if (go_reg && empty) begin
							state_reg     <= PCRC_ST_FLUSH;
							flush_cnt_reg <= (flush_len == 6'h00) ? 6'h01 : flush_len;
						end else begin
							state_reg <= PCRC_ST_IDLE;
						end
					end
				end
				PCRC_ST_FLUSH: begin
					if (!go_reg || flush_cnt_reg <= 6'h01) begin
						state_reg <= PCRC_ST_IDLE;
					end else begin
						flush_cnt_reg <= flush_cnt_reg - 6'h01;
					end
				end
				default: begin
					state_reg <= PCRC_ST_IDLE;
				end
			endcase
		end
	end

	// buffer register: left aligned for msb first, right aligned for lsb first
	always_ff @(posedge clk) begin
		if (srst || !cfg_reg.enable) begin
			buf_reg       <= `PCRC_ZERO32;
			bits_left_reg <= 6'h00;
		end else if (state_reg == PCRC_ST_LOAD) begin
			buf_reg       <= cfg_reg.dir ? masked : (masked << (`PCRC_MAX_IDX - cfg_reg.dwidth));
			bits_left_reg <= {1'b0, cfg_reg.dwidth} + 6'h01;
		end else if (shift_en) begin
			buf_reg       <= cfg_reg.dir ? (buf_reg >> 2) : (buf_reg << 2);
			bits_left_reg <= last_shift ? 6'h00 : (bits_left_reg - 6'h02);
		end
	end

	assign shift_en = (state_reg == PCRC_ST_SHIFT) & (bits_left_reg != 6'h00);
	assign bit_a    = cfg_reg.dir ? buf_reg[0] : buf_reg[31];
	assign bit_b    = cfg_reg.dir ? buf_reg[1] : buf_reg[30];

	pcrc_engine u_engine (
		.clk      (clk),
		.srst     (srst),
		.clear    (~cfg_reg.enable),
		.wr_lo    (wr_rlo),
		.wr_hi    (wr_rhi),
		.wr_data  (wdata16),
		.wr_be    (be16),
		.shift_en (shift_en),
		.two_bits (bits_left_reg != 6'h01),
		.bit_a    (bit_a),
		.bit_b    (bit_b),
		.poly     ({terms_reg, 1'b1}),
		.plen     (cfg_reg.plen),
		.result   (result)
	);

	// ======================================================================
	// interrupt pulse: count one-to-zero or hardware completion
	always_ff @(posedge clk) begin
		if (srst) begin
			crc_irq <= 1'b0;
		end else begin
			crc_irq <= (pop & ~push & (count_reg == 5'h01) & ~cfg_reg.isel)
				| (done_pulse & cfg_reg.isel);
		end
	end

endmodule : pcrc_top

//--- bench/pcrc_top_asserts.sv
// checker of the crc generator register port and event output
// assumes it is bound to pcrc_top and sees only that module's ports
`include "pcrc_cfg.svh"

module pcrc_top_asserts (
	// clock and reset
	input wire logic        clk,
	input wire logic        srst,
	// avalon-mm slave
	input wire logic [4:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	// event output
	input wire logic        crc_irq
);
	logic en_reg;

	// ======================================================================
	// helper logic
	// shadow of the module enable bit as software last wrote it
	always_ff @(posedge clk) begin
		if (srst) begin
			en_reg <= 1'h0;
		end else if (avs_write && avs_address == `PCRC_OFF_CONTROL && avs_byteenable[1]) begin
			en_reg <= avs_writedata[`PCRC_CTL_EN];
		end
	end

	// ======================================================================
	// read handshake steps and the assertions on the register port and event output
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	sequence s_rd_wait;
		avs_read && avs_waitrequest;
	endsequence
	sequence s_rd_done;
		avs_read && !avs_waitrequest;
	endsequence

	a_write_nowait: assert property (avs_write |-> !avs_waitrequest)
		else $error("write was stalled");
	a_read_first: assert property ($rose(avs_read) |-> avs_waitrequest)
		else $error("read answered without its wait cycle");
	a_read_onewait: assert property (s_rd_wait |=> !avs_read || !avs_waitrequest)
		else $error("read stalled more than one cycle");
	a_data_zero: assert property (s_rd_done ##0 avs_address[4:3] == 2'h2
		|-> avs_readdata == 32'h00000000) else $error("data pair read not zero");
	a_unmapped_zero: assert property (s_rd_done ##0 avs_address[1:0] != 2'h0
		|-> avs_readdata == 32'h00000000) else $error("unmapped read not zero");
	a_terms_bit0: assert property (s_rd_done ##0 avs_address == `PCRC_OFF_TERMS_LO
		|-> avs_readdata[0] == 1'h0 && avs_readdata[31:16] == 16'h0000)
		else $error("zero-order term bit reads set");
	a_flag_match: assert property (s_rd_done ##0 avs_address == `PCRC_OFF_CONTROL
		|-> avs_readdata[6] == (avs_readdata[12:8] == 5'h00) && (!avs_readdata[7]
		|| avs_readdata[12:8] inside {5'h04, 5'h08, 5'h10}))
		else $error("status flags disagree with word count");
	a_disabled_empty: assert property (s_rd_done ##0 avs_address == `PCRC_OFF_CONTROL
		##0 !en_reg |-> avs_readdata[12:6] == 7'h01) else $error("disabled fifo not empty");
	a_irq_pulse: assert property (crc_irq |=> !crc_irq)
		else $error("event output longer than one cycle");
	a_irq_disabled: assert property ((!en_reg) [*3] |-> !crc_irq)
		else $error("event while module disabled");
endmodule : pcrc_top_asserts

bind pcrc_top pcrc_top_asserts u_pcrc_chk (
	.clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .crc_irq(crc_irq)
);

//--- bench/pcrc_top_tb_top.sv
// self-checking bench of the crc generator through its register port
// assumes the design files, pcrc_cfg.svh and the checker are compiled first
`include "pcrc_cfg.svh"

module pcrc_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import pcrc_pkg::*;

	localparam logic [4:0] a_ctl = `PCRC_OFF_CONTROL;
	localparam logic [4:0] a_cfg = `PCRC_OFF_CONFIG;
	localparam logic [4:0] a_tlo = `PCRC_OFF_TERMS_LO;
	localparam logic [4:0] a_thi = `PCRC_OFF_TERMS_HI;
	localparam logic [4:0] a_dlo = `PCRC_OFF_DATA_LO;
	localparam logic [4:0] a_dhi = `PCRC_OFF_DATA_HI;
	localparam logic [4:0] a_rlo = `PCRC_OFF_RESULT_LO;
	localparam logic [4:0] a_rhi = `PCRC_OFF_RESULT_HI;
	localparam logic [4:0] fd_w [6] = '{5'h1F, 5'h10, 5'h0F, 5'h08, 5'h07, 5'h00};
	localparam int         fd_d [6] = '{4, 4, 8, 8, 16, 16};

	logic        clk = 1'h0;
	logic        srst = 1'h1;
	logic [4:0]  avs_address = 5'h00;
	logic        avs_read = 1'h0;
	logic        avs_write = 1'h0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [3:0]  avs_byteenable = 4'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        crc_irq;
	logic [15:0] q;
	int          fail_count = 0;
	int          num_checks = 0;
	int          irq_cnt = 0;

	// ======================================================================
	// clock, design and event counter
	always #20 clk = ~clk;

	pcrc_top DUT (
		.clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .crc_irq(crc_irq)
	);

	// counts one-cycle event pulses
	always @(posedge clk) begin
		if (crc_irq === 1'h1) begin
			irq_cnt <= irq_cnt + 1;
		end
	end

	// ======================================================================
	// shared tasks
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// one bus cycle: held until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [4:0] a, input logic [15:0] d,
		input logic [1:0] be);
		logic w;
		int   n;
		w = 1'h1;
		n = 0;
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= {16'h0000, d};
		avs_byteenable <= {2'h0, be};
		while (w !== 1'h0) begin
			@(posedge clk);
			w = avs_waitrequest;
			q = avs_readdata[15:0];
			n++;
		end
		chk("wait cycles", n, wr ? 1 : 2);
		avs_write <= 1'h0;
		avs_read <= 1'h0;
		@(posedge clk);
	endtask : bus

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		bus(1'h1, a, d, 2'h3);
	endtask : wr

	task automatic rd(input logic [4:0] a);
		bus(1'h0, a, 16'h0000, 2'h3);
	endtask : rd

	// reference crc: register not reflected, direction picks input bit order
	function automatic logic [31:0] crc_ref(input logic [31:0] c, input logic [31:0] din,
		input int w, input int n, input logic [31:0] t, input logic dir);
		logic [31:0] m;
		logic [31:0] p;
		logic        fb;
		m = (n == 32) ? 32'hFFFFFFFF : ((32'h00000001 << n) - 32'h00000001);
		p = {t[31:1], 1'h1} & m;
		for (int i = 0; i < w; i++) begin
			fb = (dir ? din[i] : din[w - 1 - i]) ^ c[n - 1];
			c = ((c << 1) & m) ^ (fb ? p : 32'h00000000);
		end
		return c;
	endfunction : crc_ref

	// ======================================================================
	// scenarios
	task automatic t_reset_vals();
		rd(a_ctl);
		chk("control at reset", q, 16'h0040);
		wr(a_tlo, 16'hFFFF);
		rd(a_tlo);
		chk("terms low readback", q, 16'hFFFE);
		wr(5'h02, 16'hFFFF);
		rd(5'h02);
		chk("unmapped read", q, 16'h0000);
	endtask : t_reset_vals

	// fills the fifo past its depth, top byte of the width last
	task automatic t_fifo_depth(input logic [4:0] dw, input int depth);
		wr(a_ctl, 16'h8000);
		wr(a_cfg, {3'h0, dw, 8'h00});
		for (int k = 0; k <= depth; k++) begin
			bus(1'h1, a_dlo, 16'h5AA5, 2'h1);
			if (dw > 5'h07) begin
				rd(a_ctl);
				chk("count before top byte", q[12:8], (k < depth) ? k : depth);
				bus(1'h1, dw[4] ? a_dhi : a_dlo, 16'hA55A, dw[4] ? 2'h3 : 2'h2);
			end
			rd(a_ctl);
			chk("word count", q[12:8], (k < depth) ? k + 1 : depth);
			chk("full flag", q[7], k + 1 >= depth);
		end
		rd(a_dhi);
		chk("data pair read", q, 16'h0000);
		wr(a_ctl, 16'h0000);
		rd(a_ctl);
		chk("disabled status", q, 16'h0040);
	endtask : t_fifo_depth

	// full calculation; late sets go before any data is written
	task automatic run_crc(input logic [4:0] dw, input logic [4:0] pl, input logic [31:0] t,
		input logic dir, input logic isel, input logic late, input logic [31:0] ws[$]);
		logic [15:0] mode;
		logic [15:0] lo;
		logic [31:0] exp;
		int          ic;
		mode = {8'h80, 2'h0, isel, 1'h0, dir, 3'h0};
		exp = 32'h00000000;
		ic = irq_cnt;
		wr(a_ctl, mode);
		wr(a_cfg, {3'h0, dw, 3'h0, pl});
		wr(a_tlo, t[15:0]);
		wr(a_thi, t[31:16]);
		wr(a_rlo, 16'h0000);
		wr(a_rhi, 16'h0000);
		wr(a_ctl, late ? (mode | 16'h0010) : mode);
		foreach (ws[k]) begin
			wr(a_dlo, ws[k][15:0]);
			if (dw[4]) begin
				wr(a_dhi, ws[k][31:16]);
			end
			exp = crc_ref(exp, ws[k], int'(dw) + 1, int'(pl) + 1, t, dir);
		end
		if (!late) begin
			wr(a_ctl, mode | 16'h0010);
		end
		q = 16'h0010;
		for (int i = 0; i < 100 && q[4] === 1'h1; i++) begin
			rd(a_ctl);
		end
		chk("control after run", q, mode | 16'h0040);
		chk("event count", irq_cnt - ic, 1);
		rd(a_rlo);
		lo = q;
		rd(a_rhi);
		chk("crc result", {q, lo}, exp);
	endtask : run_crc

	// software clears go while waiting on an empty fifo
	task automatic t_sw_stop();
		int ic;
		ic = irq_cnt;
		wr(a_ctl, 16'h8030);
		repeat (8) @(posedge clk);
		wr(a_ctl, 16'h8020);
		repeat (20) @(posedge clk);
		chk("event on software stop", irq_cnt - ic, 0);
	endtask : t_sw_stop

	// ======================================================================
	// verdict, watchdog and main sequence
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : summarize

	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		$display("MISMATCH watchdog expected finish seen timeout");
		summarize();
	end

	initial begin
		repeat (12) @(posedge clk);
		srst <= 1'h0;
		t_reset_vals();
		foreach (fd_w[i]) begin
			t_fifo_depth(fd_w[i], fd_d[i]);
		end
		run_crc(5'h07, 5'h0F, 32'h00011021, 1'h0, 1'h1, 1'h0, '{32'h31, 32'h32, 32'h33});
		run_crc(5'h07, 5'h0F, 32'h00011021, 1'h1, 1'h0, 1'h0, '{32'h31, 32'h32, 32'h33});
		run_crc(5'h1F, 5'h1F, 32'h04C11DB7, 1'h0, 1'h0, 1'h0, '{32'h12345678, 32'hDEADBEEF});
		run_crc(5'h05, 5'h07, 32'h00000107, 1'h0, 1'h1, 1'h1, '{32'h000000FF});
		run_crc(5'h0C, 5'h04, 32'h00000005, 1'h1, 1'h1, 1'h0, '{32'h0ABC, 32'hF123});
		t_sw_stop();
		summarize();
	end
endmodule : pcrc_top_tb_top
